// *** pkg/fsp_pkg.sv ***
// Purpose: Shared constants and types for the flash stream prefetch engine
// Assumes: Byte offsets on the register port, 32-bit data
// Notes:   Full and empty status bits are derived from the FIFO level count

package fsp_pkg;

    // Register port geometry
    localparam int unsigned       FSP_ADDR_W     = 8;
    localparam int unsigned       FSP_DATA_W     = 32;
    localparam int unsigned       FSP_CNT_W      = 22;
    localparam int unsigned       FSP_WADDR_W    = 30;
    localparam int unsigned       FSP_FIFO_DEPTH = 2;

    // Register byte offsets
    localparam logic [7:0]        FSP_OFS_STAT   = 8'h08;
    localparam logic [7:0]        FSP_OFS_ADDR   = 8'h14;
    localparam logic [7:0]        FSP_OFS_CNT    = 8'h18;
    localparam logic [7:0]        FSP_OFS_DATA   = 8'h1C;

    // Field positions
    localparam int unsigned       FSP_STAT_EMPTY = 1;
    localparam int unsigned       FSP_STAT_FULL  = 2;
    localparam int unsigned       FSP_ADDR_LSB   = 2;

    // Reset values
    localparam logic [29:0]       FSP_RST_ADDR   = 30'h0;
    localparam logic [21:0]       FSP_RST_CNT    = 22'h0;
    localparam logic [31:0]       FSP_RST_DATA   = 32'h0;

    // Stream engine states
    typedef enum logic [1:0] {
        FSP_ST_IDLE = 2'b01,
        FSP_ST_WAIT = 2'b10
    } fsp_state_e;

    // One register port request
    typedef struct packed {
        logic                     req;
        logic                     we;
        logic [7:0]               addr;
        logic [31:0]              wdata;
    } fsp_reg_req_s;

    // One flash read request
    typedef struct packed {
        logic                     valid;
        logic [29:0]              waddr;
    } fsp_flash_req_s;

endpackage : fsp_pkg

// *** core/fsp_fifo.sv ***
// Purpose: Small synchronous FIFO holding streamed flash words
// Assumes: Single clock, push and pop may share a cycle
// Notes:   Full and empty come from an explicit level count

`timescale 1ns/100ps
`default_nettype none

module fsp_fifo #(
    parameter int unsigned W     = 32,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic                       clk_sys,
    input  wire logic                       resetn,
    input  wire logic                       push_valid,
    output logic                            push_ready,
    input  wire logic [W-1:0]               push_data,
    output logic                            pop_valid,
    input  wire logic                       pop_ready,
    output logic [W-1:0]                    pop_data
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned LW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [LW-1:0] LVL_FULL = LW'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [LW-1:0] level_r;
    logic          do_push;
    logic          do_pop;

    // Never accept into a full FIFO, so nothing is overwritten
    assign push_ready = (level_r != LVL_FULL);
    assign pop_valid  = (level_r != '0);
    assign pop_data   = mem[rd_ptr_r];
    assign do_push    = push_valid & push_ready;
    assign do_pop     = pop_valid & pop_ready;

    // Storage, no reset needed for data
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

    // Pointers wrap at the last slot, depth need not be a power of two
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + PW'(1);
            end
            if (do_pop) begin
                rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + PW'(1);
            end
        end
    end

    // Level tracking
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            level_r <= '0;
        end else if (do_push && !do_pop) begin
            level_r <= level_r + LW'(1);
        end else if (do_pop && !do_push) begin
            level_r <= level_r - LW'(1);
        end
    end

endmodule : fsp_fifo

`default_nettype wire

// *** core/fsp_top.sv ***
// Purpose: Background flash streaming engine feeding a small word FIFO
// Assumes: Flash side is same-clock logic with one read in flight at most
// Notes:   FIFO drains through the register port or the auxiliary port
//
// Operation
// R1 - The next stream word address is held in bits 31:2 and bits 1:0 read zero.
// R2 - The stream address steps by one word on every streaming flash read.
// R3 - Software loads the start address before writing a nonzero count.
// R4 - A 22-bit remaining count sits in bits 21:0 and a nonzero write starts a stream.
// R5 - Stream reads go out only while the flash interface reports idle.
// R6 - The count drops by one per word and reads stop when it reaches zero.
// R7 - Writing zero to the count halts the stream and drops any read in flight.
// R8 - After a halt software drains the FIFO and rewrites the address first.
// R9 - Streamed words queue in a FIFO and each data read pops the oldest.
// R10 - The same FIFO is also drained through a separate auxiliary port.
// R11 - After reset address and count both read zero so no stream runs.
// R12 - The FIFO is two words deep with full and empty flags for software.
// R13 - Empty reads one after reset and whenever no word is held, full resets to zero.
// R14 - Stream reads pause while the FIFO is full and no word is ever lost.

`timescale 1ns/100ps
`default_nettype none

module fsp_top
    import fsp_pkg::*;
#(
    parameter int unsigned DEPTH = FSP_FIFO_DEPTH
) (
    input  wire logic                       clk_sys,
    input  wire logic                       resetn,
    // Register port
    input  wire fsp_reg_req_s               reg_in,
    output logic                            reg_ack,
    output logic [FSP_DATA_W-1:0]           reg_rdata,
    // Auxiliary stream port
    input  wire logic                       aux_req,
    output logic                            aux_ack,
    output logic [FSP_DATA_W-1:0]           aux_rdata,
    // Flash interface
    input  wire logic                       flash_idle,
    output fsp_flash_req_s                  flash_req,
    input  wire logic                       flash_rvalid,
    input  wire logic [FSP_DATA_W-1:0]      flash_rdata
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    fsp_state_e                  state_r;
    fsp_state_e                  state_nxt;
    logic [FSP_WADDR_W-1:0]      addr_r;
    logic [FSP_CNT_W-1:0]        cnt_r;
    logic                        discard_r;
    fsp_flash_req_s              flash_req_r;
    logic                        reg_ack_r;
    logic [FSP_DATA_W-1:0]       reg_rdata_r;
    logic                        aux_ack_r;
    logic [FSP_DATA_W-1:0]       aux_rdata_r;

    logic                        wr_addr;
    logic                        wr_cnt;
    logic                        rd_data;
    logic                        aux_take;
    logic                        issue;
    logic                        resp;
    logic                        halt;
    logic                        push_valid;
    logic                        push_ready;
    logic                        pop_valid;
    logic                        pop_ready;
    logic [FSP_DATA_W-1:0]       pop_data;

    ////////////////////////////////////////////////////////////////////////
    // Decode and stream control

    // Register port strobes
    assign wr_addr = reg_in.req & reg_in.we & (reg_in.addr == FSP_OFS_ADDR);
    assign wr_cnt  = reg_in.req & reg_in.we & (reg_in.addr == FSP_OFS_CNT);
    assign rd_data = reg_in.req & !reg_in.we & (reg_in.addr == FSP_OFS_DATA);

    // Register pops win; aux waits a cycle rather than sharing the slot
    assign aux_take  = aux_req & !aux_ack_r & pop_valid & !rd_data;
    assign pop_ready = (rd_data & pop_valid) | aux_take; // R9 R10

    // Issue only into free FIFO space with no software update in this cycle
    assign issue = (state_r == FSP_ST_IDLE) & (cnt_r != '0) // R6
                 & flash_idle                               // R5
                 & push_ready                               // R14
                 & !wr_addr & !wr_cnt;
    assign resp  = (state_r == FSP_ST_WAIT) & flash_rvalid;

    // Zero count write; also blocks a response landing in the same cycle
    assign halt       = wr_cnt & (reg_in.wdata[FSP_CNT_W-1:0] == '0);

    // A halted read still returns, but its word is thrown away
    assign push_valid = resp & !discard_r & !halt; // R7

    // Next state: at most one flash read outstanding
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FSP_ST_IDLE: begin
                if (issue) begin
                    state_nxt = FSP_ST_WAIT;
                end
            end
            FSP_ST_WAIT: begin
                if (flash_rvalid) begin
                    state_nxt = FSP_ST_IDLE;
                end
            end
            default: begin
                state_nxt = FSP_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r <= FSP_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stream address and count

    // Word address, low byte bits are not stored at all
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            addr_r <= FSP_RST_ADDR; // R11
        end else if (wr_addr) begin
            addr_r <= reg_in.wdata[31:FSP_ADDR_LSB]; // R1
        end else if (issue) begin
            addr_r <= addr_r + FSP_WADDR_W'(1); // R2
        end
    end

    // Remaining words; a nonzero write starts, a zero write halts
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= FSP_RST_CNT; // R11
        end else if (wr_cnt) begin
            cnt_r <= reg_in.wdata[FSP_CNT_W-1:0]; // R4 R7
        end else if (issue) begin
            cnt_r <= cnt_r - FSP_CNT_W'(1); // R6
        end
    end

    // Drop marker for a read halted while in flight
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            discard_r <= 1'b0;
        end else if (resp) begin
            discard_r <= 1'b0;
        end else if (halt && (state_r == FSP_ST_WAIT)) begin
            discard_r <= 1'b1; // R7
        end
    end

    // Flash request, one-cycle pulse carrying the current word address
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flash_req_r <= '0;
        end else begin
            flash_req_r.valid <= issue; // R5
            if (issue) begin
                flash_req_r.waddr <= addr_r; // R2
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stream FIFO

    fsp_fifo #(
        .W          (FSP_DATA_W),
        .DEPTH      (DEPTH)
    ) u_fifo (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .push_valid (push_valid),
        .push_ready (push_ready),
        .push_data  (flash_rdata),
        .pop_valid  (pop_valid),
        .pop_ready  (pop_ready),
        .pop_data   (pop_data)
    ); // R9 R12

    ////////////////////////////////////////////////////////////////////////
    // Register read path

    // Answer every access one cycle later; unmapped offsets read zero
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_ack_r   <= 1'b0;
            reg_rdata_r <= FSP_RST_DATA;
        end else begin
            reg_ack_r   <= reg_in.req;
            reg_rdata_r <= FSP_RST_DATA;
            if (reg_in.req && !reg_in.we) begin
                case (reg_in.addr)
                    FSP_OFS_STAT: begin
                        reg_rdata_r[FSP_STAT_FULL]  <= !push_ready; // R12 R13
                        reg_rdata_r[FSP_STAT_EMPTY] <= !pop_valid;  // R13
                    end
                    FSP_OFS_ADDR: begin
                        reg_rdata_r <= {addr_r, 2'b00}; // R1
                    end
                    FSP_OFS_CNT: begin
                        reg_rdata_r <= {10'h0, cnt_r}; // R4
                    end
                    FSP_OFS_DATA: begin
                        // Empty FIFO reads zero instead of stalling
                        if (pop_valid) begin
                            reg_rdata_r <= pop_data; // R9
                        end
                    end
                    default: begin
                        reg_rdata_r <= FSP_RST_DATA;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Auxiliary port

    // Holds the request until a word exists, so the DMA just waits
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aux_ack_r   <= 1'b0;
            aux_rdata_r <= FSP_RST_DATA;
        end else begin
            aux_ack_r <= aux_take; // R10
            if (aux_take) begin
                aux_rdata_r <= pop_data;
            end
        end
    end

    // Outputs straight from flops
    assign reg_ack   = reg_ack_r;
    assign reg_rdata = reg_rdata_r;
    assign aux_ack   = aux_ack_r;
    assign aux_rdata = aux_rdata_r;
    assign flash_req = flash_req_r;

endmodule : fsp_top

`default_nettype wire

// *** dv/fsp_assertions.sv ***
// Purpose: Port checks for the flash stream prefetch engine
// Assumes: One clock, reset active low
// Notes:   Bound to fsp_top from the bench top file
`timescale 1ns/100ps
`default_nettype none
module fsp_assertions
    import fsp_pkg::*;
(
    input wire logic           clk_sys,
    input wire logic           resetn,
    input wire fsp_reg_req_s   reg_in,
    input wire logic           reg_ack,
    input wire logic [31:0]    reg_rdata,
    input wire logic           aux_req,
    input wire logic           aux_ack,
    input wire logic [31:0]    aux_rdata,
    input wire logic           flash_idle,
    input wire fsp_flash_req_s flash_req,
    input wire logic           flash_rvalid,
    input wire logic [31:0]    flash_rdata
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////
    // Track the read in flight and the last streamed word address
    logic        pend_r;
    logic        seen_r;
    logic        wr_addr_r;
    logic [29:0] last_r;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pend_r    <= 1'b0;
            seen_r    <= 1'b0;
            wr_addr_r <= 1'b0;
            last_r    <= 30'h0;
        end else begin
            pend_r <= flash_req.valid | (pend_r & ~flash_rvalid);
            // An address write breaks the linear run, so it wins
            if (reg_in.req && reg_in.we && reg_in.addr == FSP_OFS_ADDR) begin
                wr_addr_r <= 1'b1;
            end else if (flash_req.valid) begin
                wr_addr_r <= 1'b0;
            end
            if (flash_req.valid) begin
                seen_r <= 1'b1;
                last_r <= flash_req.waddr;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    chk_ack_follows: assert property (reg_in.req |=> reg_ack)
        else $error("register access not acknowledged");
    chk_ack_quiet: assert property (!reg_in.req |=> !reg_ack && reg_rdata == 32'h0)
        else $error("stray register answer");
    chk_addr_low_zero: assert property (reg_in.req && !reg_in.we &&
        reg_in.addr == FSP_OFS_ADDR |=> reg_rdata[1:0] == 2'h0)
        else $error("address low bits not zero");
    chk_cnt_high_zero: assert property (reg_in.req && !reg_in.we &&
        reg_in.addr == FSP_OFS_CNT |=> reg_rdata[31:22] == 10'h0)
        else $error("count high bits not zero");
    chk_issue_idle: assert property (flash_req.valid |-> $past(flash_idle))
        else $error("read issued while flash busy");
    chk_single_read: assert property (flash_req.valid |-> !pend_r)
        else $error("second read while one in flight");
    chk_read_pulse: assert property (flash_req.valid |=> !flash_req.valid)
        else $error("read request longer than one cycle");
    chk_addr_step: assert property (flash_req.valid && seen_r && !wr_addr_r
        |-> flash_req.waddr == last_r + 30'h1)
        else $error("stream address not linear");
    chk_aux_pulse: assert property (aux_ack |=> !aux_ack)
        else $error("aux ack longer than one cycle");
    chk_aux_cause: assert property (aux_ack |-> $past(aux_req))
        else $error("aux ack without request");
    chk_aux_hold: assert property (!aux_ack |-> $stable(aux_rdata))
        else $error("aux data moved without ack");
    chk_stat_flags: assert property (reg_in.req && !reg_in.we &&
        reg_in.addr == FSP_OFS_STAT |=> !(reg_rdata[2] && reg_rdata[1]))
        else $error("FIFO full and empty at once");
endmodule : fsp_assertions
`default_nettype wire

// *** dv/fsp_flash_model.sv ***
// Purpose: Same-clock flash read responder for the stream engine
// Assumes: One read in flight, latency set by the bench
// Notes:   Word is its byte address XOR a fixed pattern
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_model
    import fsp_pkg::*;
(
    input wire logic           clk_sys,
    input wire logic           resetn,
    input wire fsp_flash_req_s flash_req,
    input wire logic           stall,
    input wire logic [7:0]     lat,
    output logic               flash_idle,
    output logic               flash_rvalid,
    output logic [31:0]        flash_rdata
);
    logic        busy_r;
    logic [7:0]  wait_r;
    logic [29:0] a_r;
    // Busy while a read is in flight or the bench holds it off
    assign flash_idle = !stall && !busy_r;
    ////////////////////////////////////////////////////////////////////////////
    // Data toggles between answers so stale words never look valid
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            busy_r       <= 1'b0;
            wait_r       <= 8'h0;
            a_r          <= 30'h0;
            flash_rvalid <= 1'b0;
            flash_rdata  <= 32'h0;
        end else begin
            flash_rvalid <= 1'b0;
            flash_rdata  <= ~flash_rdata;
            if (flash_req.valid) begin
                busy_r <= 1'b1;
                wait_r <= lat;
                a_r    <= flash_req.waddr;
            end else if (busy_r && wait_r == 8'h0) begin
                busy_r       <= 1'b0;
                flash_rvalid <= 1'b1;
                flash_rdata  <= {a_r, 2'h0} ^ 32'h5A5A_0000;
            end else if (busy_r) begin
                wait_r <= wait_r - 8'h1;
            end
        end
    end
endmodule : fsp_flash_model
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: Register level tests of the flash stream prefetch engine
// Assumes: Inputs change on the falling clock edge
// Notes:   Run is about two hundred cycles, cut off at 2000
`timescale 1ns/100ps
`default_nettype none
module tb import fsp_pkg::*;;
    logic           clk_sys = 1'b0;
    logic           resetn;
    fsp_reg_req_s   reg_in;
    logic           reg_ack;
    logic [31:0]    reg_rdata;
    logic           aux_req;
    logic           aux_ack;
    logic [31:0]    aux_rdata;
    logic           flash_idle;
    fsp_flash_req_s flash_req;
    logic           flash_rvalid;
    logic [31:0]    flash_rdata;
    logic           stall;
    logic [7:0]     lat;
    int             n_errors = 0;
    int             compares = 0;
    int             cycles = 0;
    always #5 clk_sys = ~clk_sys;
    fsp_top uut (.clk_sys(clk_sys), .resetn(resetn), .reg_in(reg_in), .reg_ack(reg_ack),
        .reg_rdata(reg_rdata), .aux_req(aux_req), .aux_ack(aux_ack), .aux_rdata(aux_rdata),
        .flash_idle(flash_idle), .flash_req(flash_req), .flash_rvalid(flash_rvalid),
        .flash_rdata(flash_rdata));
    fsp_flash_model flash (.clk_sys(clk_sys), .resetn(resetn), .flash_req(flash_req),
        .stall(stall), .lat(lat), .flash_idle(flash_idle), .flash_rvalid(flash_rvalid),
        .flash_rdata(flash_rdata));
    ////////////////////////////////////////////////////////////////////////////
    // Shared compare, register and aux transfers
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s exp %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(negedge clk_sys);
        reg_in = '{req: 1'b1, we: 1'b1, addr: a, wdata: v};
        @(negedge clk_sys);
        reg_in.req = 1'b0;
    endtask : reg_wr
    task automatic rd_exp(input string n, input logic [7:0] a, input logic [31:0] e);
        @(negedge clk_sys);
        reg_in = '{req: 1'b1, we: 1'b0, addr: a, wdata: 32'h0};
        @(negedge clk_sys);
        reg_in.req = 1'b0;
        chk(n, reg_rdata, e);
        chk("reg_ack", {31'h0, reg_ack}, 32'h1);
    endtask : rd_exp
    // Holds the request until the ack, bounded so a stuck port ends
    task automatic aux_exp(input logic [31:0] e);
        @(negedge clk_sys);
        aux_req = 1'b1;
        for (int i = 0; i < 100 && aux_ack !== 1'b1; i++) begin
            @(negedge clk_sys);
        end
        aux_req = 1'b0;
        chk("aux_ack", {31'h0, aux_ack}, 32'h1);
        chk("aux_rdata", aux_rdata, e);
    endtask : aux_exp
    task automatic wrap_up;
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////
    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reg_in = '0;
        aux_req = 1'b0;
        stall = 1'b0;
        lat = 8'h2;
        resetn = 1'b0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        resetn = 1'b1;
        rd_exp("addr", FSP_OFS_ADDR, 32'h0);
        rd_exp("count", FSP_OFS_CNT, 32'h0);
        rd_exp("status", FSP_OFS_STAT, 32'h2);
        rd_exp("data", FSP_OFS_DATA, 32'h0);
        rd_exp("unmapped", 8'h20, 32'h0);
        // Reserved bits, with the flash held busy so nothing streams
        stall = 1'b1;
        reg_wr(FSP_OFS_ADDR, 32'hFFFF_FFFF);
        rd_exp("addr", FSP_OFS_ADDR, 32'hFFFF_FFFC);
        reg_wr(FSP_OFS_CNT, 32'hFFFF_FFFF);
        rd_exp("count", FSP_OFS_CNT, 32'h003F_FFFF);
        reg_wr(FSP_OFS_CNT, 32'h0);
        stall = 1'b0;
        repeat (10) @(negedge clk_sys);
        rd_exp("status", FSP_OFS_STAT, 32'h2);
        // Three words into a two deep FIFO, third waits for space
        reg_wr(FSP_OFS_ADDR, 32'h100);
        reg_wr(FSP_OFS_CNT, 32'h3);
        repeat (30) @(negedge clk_sys);
        rd_exp("status", FSP_OFS_STAT, 32'h4);
        rd_exp("count", FSP_OFS_CNT, 32'h1);
        rd_exp("data", FSP_OFS_DATA, 32'h5A5A_0100);
        rd_exp("data", FSP_OFS_DATA, 32'h5A5A_0104);
        aux_exp(32'h5A5A_0108);
        rd_exp("status", FSP_OFS_STAT, 32'h2);
        rd_exp("count", FSP_OFS_CNT, 32'h0);
        rd_exp("addr", FSP_OFS_ADDR, 32'h10C);
        // Halt with a slow read in flight; its word must vanish
        lat = 8'h14;
        reg_wr(FSP_OFS_ADDR, 32'h200);
        reg_wr(FSP_OFS_CNT, 32'h5);
        repeat (3) @(negedge clk_sys);
        reg_wr(FSP_OFS_CNT, 32'h0);
        repeat (30) @(negedge clk_sys);
        rd_exp("status", FSP_OFS_STAT, 32'h2);
        rd_exp("count", FSP_OFS_CNT, 32'h0);
        // Fresh stream from a new address after the drain
        lat = 8'h2;
        reg_wr(FSP_OFS_ADDR, 32'h300);
        reg_wr(FSP_OFS_CNT, 32'h1);
        repeat (10) @(negedge clk_sys);
        rd_exp("data", FSP_OFS_DATA, 32'h5A5A_0300);
        // Halt sampled on the very edge the read answer arrives
        reg_wr(FSP_OFS_ADDR, 32'h500);
        reg_wr(FSP_OFS_CNT, 32'h1);
        repeat (4) @(negedge clk_sys);
        reg_wr(FSP_OFS_CNT, 32'h0);
        repeat (10) @(negedge clk_sys);
        rd_exp("status", FSP_OFS_STAT, 32'h2);
        // No stream read while the flash is busy
        stall = 1'b1;
        reg_wr(FSP_OFS_ADDR, 32'h400);
        reg_wr(FSP_OFS_CNT, 32'h1);
        repeat (20) @(negedge clk_sys);
        rd_exp("status", FSP_OFS_STAT, 32'h2);
        stall = 1'b0;
        aux_exp(32'h5A5A_0400);
        wrap_up();
    end
endmodule : tb
bind fsp_top fsp_assertions chk (.clk_sys(clk_sys), .resetn(resetn), .reg_in(reg_in),
    .reg_ack(reg_ack), .reg_rdata(reg_rdata), .aux_req(aux_req), .aux_ack(aux_ack),
    .aux_rdata(aux_rdata), .flash_idle(flash_idle), .flash_req(flash_req),
    .flash_rvalid(flash_rvalid), .flash_rdata(flash_rdata));
`default_nettype wire
